// *** src/i2c_ctrl_pkg.sv ***
// shared constants, types and helpers of the paged control port
package i2c_ctrl_pkg;

  // ------------------------------------------------------------
  // bus addressing
  // ------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h18;
  localparam logic [6:0] GC_ADDR = 7'h00;

  // ------------------------------------------------------------
  // register offsets within a page
  // ------------------------------------------------------------
  localparam logic [7:0] REG_PAGE_SEL = 8'h00;
  localparam logic [7:0] REG_SW_RESET = 8'h01;
  localparam logic [7:0] REG_RSVD_A = 8'h02;
  localparam logic [7:0] REG_OT_FLAG = 8'h03;
  localparam logic [7:0] REG_RSVD_B = 8'h09;
  localparam logic [7:0] REG_RSVD_C = 8'h0A;
  localparam logic [7:0] REG_TIMER_DIV = 8'h10;
  localparam logic [7:0] REG_GC_CTRL = 8'h22;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int GC_EN_BIT = 5;
  localparam int SW_RESET_BIT = 0;
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] OT_FLAG_VAL = 8'h02;
  localparam logic [7:0] TIMER_DIV_RST = 8'h01;
  localparam logic [7:0] MEM_RST = 8'h00;

  // ------------------------------------------------------------
  // defined pages and storage layout
  // ------------------------------------------------------------
  localparam logic [7:0] PAGE_CTRL = 8'h00;
  localparam logic [7:0] PAGE_DAC = 8'h01;
  localparam logic [7:0] PAGE_TIMER = 8'h03;
  localparam logic [7:0] PAGE_COEF_A0 = 8'h08;
  localparam logic [7:0] PAGE_COEF_A1 = 8'h09;
  localparam logic [7:0] PAGE_COEF_B0 = 8'h0C;
  localparam logic [7:0] PAGE_COEF_B1 = 8'h0D;
  localparam int NUM_BANKS = 7;
  localparam int REGS_PER_PAGE = 128;
  localparam int CLEAR_CYCLES = NUM_BANKS * REGS_PER_PAGE;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } bus_state_t;

  // {valid, bank index} of a page number
  function automatic logic [3:0] bank_of(input logic [7:0] pg);
    case (pg)
      PAGE_CTRL: bank_of = 4'h8;
      PAGE_DAC: bank_of = 4'h9;
      PAGE_TIMER: bank_of = 4'hA;
      PAGE_COEF_A0: bank_of = 4'hB;
      PAGE_COEF_A1: bank_of = 4'hC;
      PAGE_COEF_B0: bank_of = 4'hD;
      PAGE_COEF_B1: bank_of = 4'hE;
      default: bank_of = 4'h0;
    endcase
  endfunction

  // status and reserved words that ignore writes
  function automatic logic is_read_only(input logic [7:0] pg,
                                        input logic [7:0] rg);
    is_read_only = (pg == PAGE_CTRL) &&
      (rg == REG_RSVD_A || rg == REG_OT_FLAG ||
       rg == REG_RSVD_B || rg == REG_RSVD_C);
  endfunction

endpackage

// *** src/paged_i2c_control_slave.sv ***
// bus target that gives a host access to paged 8-bit control registers

module paged_i2c_control_slave
  import i2c_ctrl_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // settings and status seen by the converter core
  output logic [7:0] page_sel,
  output logic [7:0] timer_div,
  output logic gc_enable,
  output logic bus_active,
  output logic clear_busy
);

  // ------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------
  localparam int MEM_DEPTH = BANKS * REGS_PER_PAGE;
  localparam logic [9:0] LAST_IDX = 10'(MEM_DEPTH - 1);
  if (BANKS != NUM_BANKS) begin : g_bank_check
    $error("bank count must match the defined pages");
  end

  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3, scl_q;
    logic sda_s1, sda_s2, sda_s3, sda_q;
    bus_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rd_mode, first, more, oe;
    logic [7:0] ptr, page, tdiv;
    logic gc_en, clr_busy;
    logic [9:0] clr_idx;
  } ctrl_state_t;
  // sync chains idle high; storage is swept to zero after reset
  localparam ctrl_state_t STATE_RST = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, scl_q: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, sda_q: 1'b1,
    st: ST_IDLE, bit_cnt: 4'h0, shreg: 8'h00, rd_mode: 1'b0,
    first: 1'b0, more: 1'b0, oe: 1'b0, ptr: 8'h00,
    page: PAGE_SEL_RST, tdiv: TIMER_DIV_RST, gc_en: 1'b0,
    clr_busy: 1'b1, clr_idx: 10'h000
  };
  ctrl_state_t r_reg, r_next;
  logic [7:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [9:0] mem_wa;
  logic [7:0] mem_wd;

  // ------------------------------------------------------------
  // pin edge and condition detection
  // ------------------------------------------------------------
  logic scl_agree, sda_agree;
  logic scl_rise, scl_fall, sda_rise, sda_fall;
  logic start_ev, stop_ev;

  // a level counts once the second and third stages agree
  assign scl_agree = r_reg.scl_s2 == r_reg.scl_s3;
  assign sda_agree = r_reg.sda_s2 == r_reg.sda_s3;
  assign scl_rise = scl_agree && r_reg.scl_s3 && !r_reg.scl_q;
  assign scl_fall = scl_agree && !r_reg.scl_s3 && r_reg.scl_q;
  assign sda_rise = sda_agree && r_reg.sda_s3 && !r_reg.sda_q;
  assign sda_fall = sda_agree && !r_reg.sda_s3 && r_reg.sda_q;
  // data moving while the clock stays high marks start or stop
  assign start_ev = sda_fall && r_reg.scl_q && !scl_fall;
  assign stop_ev = sda_rise && r_reg.scl_q && !scl_fall;

  // ------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------
  logic [3:0] cur_bank;
  logic [7:0] mem_q, rd_byte;
  logic addr_hit, gc_hit;

  assign cur_bank = bank_of(r_reg.page);
  assign mem_q = mem[{cur_bank[2:0], r_reg.ptr[6:0]}];

  // reserved and unmapped words read zero
  always_comb begin
    if (r_reg.ptr == REG_PAGE_SEL) begin
      rd_byte = r_reg.page;
    end else if (!cur_bank[3] || r_reg.ptr[7]) begin
      rd_byte = 8'h00;
    end else if (r_reg.page == PAGE_CTRL &&
                 r_reg.ptr == REG_OT_FLAG) begin
      rd_byte = OT_FLAG_VAL;
    end else if (r_reg.page == PAGE_CTRL &&
                 (r_reg.ptr == REG_SW_RESET ||
                  is_read_only(r_reg.page, r_reg.ptr))) begin
      rd_byte = 8'h00;
    end else if (r_reg.page == PAGE_TIMER &&
                 r_reg.ptr == REG_TIMER_DIV) begin
      rd_byte = r_reg.tdiv;
    end else begin
      rd_byte = mem_q;
    end
  end

  // address byte sits whole in the shifter at the eighth fall
  assign addr_hit = r_reg.shreg[7:1] == DEV_ADDR;
  assign gc_hit = r_reg.shreg[7:1] == GC_ADDR && r_reg.gc_en &&
                  !r_reg.shreg[0];

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    mem_wa = 10'h000;
    mem_wd = MEM_RST;
    {r_next.scl_s1, r_next.scl_s2, r_next.scl_s3} =
      {scl_in, r_reg.scl_s1, r_reg.scl_s2};
    {r_next.sda_s1, r_next.sda_s2, r_next.sda_s3} =
      {sda_in, r_reg.sda_s1, r_reg.sda_s2};
    r_next.scl_q = scl_agree ? r_reg.scl_s3 : r_reg.scl_q;
    r_next.sda_q = sda_agree ? r_reg.sda_s3 : r_reg.sda_q;
    // clearing sweep; a bus write below takes the port over
    if (r_reg.clr_busy) begin
      mem_we = 1'b1;
      mem_wa = r_reg.clr_idx;
      r_next.clr_idx = r_reg.clr_idx + 10'h001;
      r_next.clr_busy = r_reg.clr_idx != LAST_IDX;
    end
    if (start_ev) begin
      r_next.st = ST_ADDR;
      r_next.bit_cnt = 4'h0;
      r_next.oe = 1'b0;
    end else if (stop_ev) begin
      r_next.st = ST_IDLE;
      r_next.oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        ST_IDLE: r_next.oe = 1'b0;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_q};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall && r_reg.bit_cnt == 4'h8) begin
            if (r_reg.st == ST_ADDR) begin
              if (addr_hit || gc_hit) begin
                r_next.st = ST_ADDR_ACK;
                r_next.oe = 1'b1;
                r_next.rd_mode = r_reg.shreg[0];
              end else begin
                r_next.st = ST_IDLE;
              end
            end else begin
              r_next.st = ST_RX_ACK;
              r_next.oe = 1'b1;
              if (r_reg.first) begin
                r_next.ptr = r_reg.shreg;
                r_next.first = 1'b0;
              end else begin
                r_next.ptr = r_reg.ptr + 8'h01;
                if (r_reg.ptr == REG_PAGE_SEL) begin
                  r_next.page = r_reg.shreg;
                end else if (cur_bank[3] && !r_reg.ptr[7] &&
                             !is_read_only(r_reg.page, r_reg.ptr)) begin
                  if (r_reg.page == PAGE_CTRL &&
                      r_reg.ptr == REG_SW_RESET) begin
                    // the bit is never stored, so it reads back zero
                    if (r_reg.shreg[SW_RESET_BIT]) begin
                      r_next.page = PAGE_SEL_RST;
                      r_next.tdiv = TIMER_DIV_RST;
                      r_next.gc_en = 1'b0;
                      r_next.clr_busy = 1'b1;
                      r_next.clr_idx = 10'h000;
                    end
                  end else begin
                    mem_we = 1'b1;
                    mem_wa = {cur_bank[2:0], r_reg.ptr[6:0]};
                    mem_wd = r_reg.shreg;
                    if (r_reg.page == PAGE_CTRL &&
                        r_reg.ptr == REG_GC_CTRL) begin
                      r_next.gc_en = r_reg.shreg[GC_EN_BIT];
                    end
                    if (r_reg.page == PAGE_TIMER &&
                        r_reg.ptr == REG_TIMER_DIV) begin
                      r_next.tdiv = r_reg.shreg;
                    end
                  end
                end
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            r_next.bit_cnt = 4'h0;
            if (r_reg.rd_mode) begin
              // first bit goes out at once, pointer kept from the write
              r_next.st = ST_TX;
              r_next.shreg = rd_byte;
              r_next.oe = !rd_byte[7];
            end else begin
              r_next.st = ST_RX;
              r_next.oe = 1'b0;
              r_next.first = 1'b1;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            r_next.st = ST_RX;
            r_next.oe = 1'b0;
            r_next.bit_cnt = 4'h0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bit_cnt == 4'h8) begin
              r_next.st = ST_TX_ACK;
              r_next.oe = 1'b0;
            end else begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.oe = !r_reg.shreg[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            r_next.more = !r_reg.sda_q;
            if (!r_reg.sda_q) begin
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          end else if (scl_fall) begin
            r_next.bit_cnt = 4'h0;
            if (r_reg.more) begin
              r_next.st = ST_TX;
              r_next.shreg = rd_byte;
              r_next.oe = !rd_byte[7];
            end else begin
              // not acknowledged: hands off until start or stop
              r_next.st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // synchronous reset: page 0, general call off, sweep started
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // storage has no reset of its own; the sweep clears it
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // open-drain data: only ever pulled low, clock is never driven
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.oe;
  assign page_sel = r_reg.page;
  assign timer_div = r_reg.tdiv;
  assign gc_enable = r_reg.gc_en;
  assign bus_active = r_reg.st != ST_IDLE;
  assign clear_busy = r_reg.clr_busy;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_addr_done;
    r_reg.st == ST_ADDR && scl_fall && r_reg.bit_cnt == 4'h8 &&
      !start_ev && !stop_ev;
  endsequence
  sequence s_data_byte;
    r_reg.st == ST_RX && scl_fall && r_reg.bit_cnt == 4'h8 &&
      !r_reg.first && !start_ev && !stop_ev;
  endsequence
  a_addr_ack_drive: assert property (
    s_addr_done ##0 addr_hit |=> r_reg.st == ST_ADDR_ACK && sda_oe)
    else $error("own address not acknowledged");
  a_addr_miss_idle: assert property (
    s_addr_done ##0 (!addr_hit && !gc_hit) |=>
      r_reg.st == ST_IDLE && !sda_oe)
    else $error("foreign address answered");
  a_start_decode: assert property (
    start_ev |=> r_reg.st == ST_ADDR && r_reg.bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not restart address decode");
  a_stop_release: assert property (
    stop_ev |=> r_reg.st == ST_IDLE && !sda_oe [*2])
    else $error("stop did not idle the port");
  a_sda_owner: assert property (
    sda_oe |-> r_reg.st inside {ST_ADDR_ACK, ST_RX_ACK, ST_TX})
    else $error("data line pulled outside own slot");
  a_tx_bit_value: assert property (
    r_reg.st == ST_TX |-> sda_oe == !r_reg.shreg[7])
    else $error("read bit driven wrong");
  a_write_inc: assert property (
    s_data_byte |=> r_reg.ptr == $past(r_reg.ptr) + 8'h01 &&
      r_reg.st == ST_RX_ACK && sda_oe)
    else $error("write pointer did not advance");
  a_read_inc: assert property (
    r_reg.st == ST_TX_ACK && scl_rise && !r_reg.sda_q &&
      !start_ev && !stop_ev |=> r_reg.ptr == $past(r_reg.ptr) + 8'h01)
    else $error("read pointer did not advance");
  a_page_write: assert property (
    s_data_byte ##0 (r_reg.ptr == REG_PAGE_SEL) |=>
      r_reg.page == $past(r_reg.shreg))
    else $error("page select not taken");
  a_sw_reset_clear: assert property (
    s_data_byte ##0 (r_reg.page == PAGE_CTRL &&
      r_reg.ptr == REG_SW_RESET && r_reg.shreg[0]) |=>
      r_reg.clr_busy && page_sel == PAGE_SEL_RST ##[1:900] !r_reg.clr_busy)
    else $error("software reset did not clear");
  a_page_reset: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> page_sel == PAGE_SEL_RST && !gc_enable)
    else $error("reset did not select page 0");
endmodule

// *** verification/i2c_host_model.sv ***
// bus host model that drives clock and data toward the control port
module i2c_host_model #(
  parameter int PHASE = 9
) (
  // pacing clock
  input wire logic clk_sys,
  // resolved data wire
  input wire logic sda_bus,
  // open-drain drives, 1 means released
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: both lines released to the pull-ups
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // one bus phase, moved off the falling system edge
  task automatic tick();
    repeat (PHASE) @(negedge clk_sys);
  endtask

  // start, or repeated start when the clock sits low
  task automatic bus_start();
    sda_drv = 1'b1;
    tick();
    scl_drv = 1'b1;
    tick();
    sda_drv = 1'b0;
    tick();
    scl_drv = 1'b0;
  endtask

  // stop: data rises while clock is high
  task automatic bus_stop();
    tick();
    sda_drv = 1'b0;
    tick();
    scl_drv = 1'b1;
    tick();
    sda_drv = 1'b1;
    tick();
  endtask

  // one clock pulse; data set before it stays put until a phase after
  task automatic pulse(output logic seen);
    tick();
    scl_drv = 1'b1;
    tick();
    seen = sda_bus;
    scl_drv = 1'b0;
    tick();
  endtask

  // send a byte msb first, then clock the target's answer
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      pulse(s);
    end
    sda_drv = 1'b1;
    pulse(s);
    ack = ~s;
  endtask

  // take a byte, then acknowledge or not
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    sda_drv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_drv = ~ack;
    pulse(s);
    sda_drv = 1'b1;
  endtask
endmodule

// *** verification/test_paged_i2c_control_slave.sv ***
// self-checking bench for the paged control port
module test_paged_i2c_control_slave import i2c_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic sys_rst;
  logic scl_drv;
  logic sda_drv;
  logic sda_bus;
  logic sda_out;
  logic sda_oe;
  logic [7:0] page_sel;
  logic [7:0] timer_div;
  logic gc_enable;
  logic bus_active;
  logic clear_busy;
  int err_count = 0;
  int total_checks = 0;

  // wired-and of both parties over the pull-up
  assign sda_bus = sda_drv & (sda_oe ? sda_out : 1'b1);

  i2c_host_model host (
    .clk_sys(clk_sys), .sda_bus(sda_bus),
    .scl_drv(scl_drv), .sda_drv(sda_drv)
  );

  paged_i2c_control_slave #(.BANKS(NUM_BANKS)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl_in(scl_drv), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .page_sel(page_sel), .timer_div(timer_div),
    .gc_enable(gc_enable), .bus_active(bus_active),
    .clear_busy(clear_busy)
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
               what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // pulling low is the only drive the target may use
  always @(negedge clk_sys) begin
    if (sda_oe === 1'b1)
      check({7'h00, sda_out}, 8'h00, "drives high");
  end

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    logic a;
    host.bus_start();
    host.send({DEV_ADDR, 1'b0}, a);
    check({7'h00, a}, 8'h01, "address ack");
    host.send(ptr, a);
    check({7'h00, a}, 8'h01, "pointer ack");
    host.send(val, a);
    check({7'h00, a}, 8'h01, "data ack");
    host.bus_stop();
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic a;
    logic [7:0] b;
    host.bus_start();
    host.send({DEV_ADDR, 1'b0}, a);
    host.send(ptr, a);
    host.bus_start();
    host.send({DEV_ADDR, 1'b1}, a);
    check({7'h00, a}, 8'h01, "read address ack");
    host.recv(1'b0, b);
    check(b, exp, "read data");
    host.bus_stop();
  endtask

  // bounded wait for the storage sweep
  task automatic wait_clear();
    int n;
    n = 0;
    while (clear_busy !== 1'b0 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check({7'h00, clear_busy}, 8'h00, "sweep end");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({7'h00, sda_oe}, 8'h00, "released");
    check(page_sel, PAGE_SEL_RST, "page at reset");
    check(timer_div, TIMER_DIV_RST, "divider at reset");
    check({7'h00, gc_enable}, 8'h00, "gc at reset");
    check({7'h00, bus_active}, 8'h00, "idle at reset");
    wait_clear();
  endtask

  task automatic t_autoinc();
    logic a;
    logic [7:0] b;
    logic [7:0] d [3];
    d = '{8'hA5, 8'h5A, 8'h3C};
    host.bus_start();
    host.send({DEV_ADDR, 1'b0}, a);
    host.send(8'h04, a);
    for (int i = 0; i < 3; i++) begin
      host.send(d[i], a);
      check({7'h00, a}, 8'h01, "burst ack");
    end
    check({7'h00, bus_active}, 8'h01, "active");
    host.bus_stop();
    check({7'h00, bus_active}, 8'h00, "idle after stop");
    host.bus_start();
    host.send({DEV_ADDR, 1'b0}, a);
    host.send(8'h04, a);
    host.bus_start();
    host.send({DEV_ADDR, 1'b1}, a);
    for (int i = 0; i < 3; i++) begin
      host.recv(i < 2, b);
      check(b, d[i], "burst read");
    end
    host.bus_stop();
  endtask

  // foreign addresses and the general call switch
  task automatic t_address();
    logic a;
    logic [6:0] bad [3];
    bad = '{7'h19, 7'h08, GC_ADDR};
    for (int i = 0; i < 3; i++) begin
      host.bus_start();
      host.send({bad[i], 1'b0}, a);
      check({7'h00, a}, 8'h00, "foreign address");
      host.bus_stop();
    end
    wr(REG_GC_CTRL, 8'h20);
    check({7'h00, gc_enable}, 8'h01, "gc on");
    // general call is a write-only address
    host.bus_start();
    host.send({GC_ADDR, 1'b1}, a);
    check({7'h00, a}, 8'h00, "gc read refused");
    host.bus_stop();
    host.bus_start();
    host.send({GC_ADDR, 1'b0}, a);
    check({7'h00, a}, 8'h01, "gc ack");
    host.send(REG_GC_CTRL, a);
    host.send(8'h00, a);
    host.bus_stop();
    check({7'h00, gc_enable}, 8'h00, "gc off");
  endtask

  // writes to read-only words are dropped
  task automatic t_readonly();
    wr(REG_OT_FLAG, OT_FLAG_VAL);
    rd(REG_OT_FLAG, OT_FLAG_VAL);
    wr(REG_RSVD_B, 8'hFF);
    rd(REG_RSVD_B, 8'h00);
  endtask

  // top register of the DAC and each coefficient page keeps its own value
  task automatic t_pages();
    logic [7:0] pg [5];
    pg = '{PAGE_DAC, PAGE_COEF_A0, PAGE_COEF_A1, PAGE_COEF_B0,
           PAGE_COEF_B1};
    wr(REG_PAGE_SEL, PAGE_TIMER);
    check(page_sel, PAGE_TIMER, "page select");
    wr(REG_TIMER_DIV, 8'h44);
    check(timer_div, 8'h44, "divider");
    rd(REG_TIMER_DIV, 8'h44);
    rd(REG_PAGE_SEL, PAGE_TIMER);
    for (int i = 0; i < 5; i++) begin
      wr(REG_PAGE_SEL, pg[i]);
      wr(8'h7F, pg[i] ^ 8'hC3);
    end
    for (int i = 0; i < 5; i++) begin
      wr(REG_PAGE_SEL, pg[i]);
      rd(8'h7F, pg[i] ^ 8'hC3);
    end
    wr(REG_PAGE_SEL, PAGE_CTRL);
    check(page_sel, PAGE_CTRL, "home page");
  endtask

  task automatic t_swreset();
    wr(REG_GC_CTRL, 8'h20);
    wr(REG_SW_RESET, 8'h01);
    check({7'h00, clear_busy}, 8'h01, "sweep runs");
    check({7'h00, gc_enable}, 8'h00, "gc cleared");
    check(timer_div, TIMER_DIV_RST, "divider reset");
    wait_clear();
    rd(REG_SW_RESET, 8'h00);
    rd(8'h04, MEM_RST);
  endtask

  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_autoinc();
    t_address();
    t_readonly();
    t_pages();
    t_swreset();
    test_done();
  end

  // the full sequence needs about 1.5 ms; a hang stops at 75k cycles
  initial begin
    #3000000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
